// ---- hdl/tpm_pkg.sv ----
`default_nettype none
package tpm_pkg;
  // port D pin positions
  localparam int unsigned PORTD_W  = 5;
  localparam int unsigned PIN_TDI  = 0;
  localparam int unsigned PIN_TDO  = 1;
  localparam int unsigned PIN_TCK  = 2;
  localparam int unsigned PIN_TMS  = 3;
  localparam int unsigned PIN_RSTN = 4;
  // reset release counter
  localparam int unsigned           RST_CNT_W       = 16;
  localparam logic [RST_CNT_W-1:0]  RST_RELEASE_DEF = 16'h0020;
  localparam logic [RST_CNT_W-1:0]  RST_CNT_ZERO    = 16'h0000;
  localparam logic [RST_CNT_W-1:0]  RST_CNT_ONE     = 16'h0001;
  localparam logic [PORTD_W-1:0]    PORTD_ZERO      = 5'h00;
  // test controller states
  localparam int unsigned TAP_W = 4;
  typedef enum logic [TAP_W-1:0] {
    TPM_RESET  = 4'hF, TPM_IDLE   = 4'hC, TPM_SEL_DR = 4'h7, TPM_CAP_DR = 4'h6,
    TPM_SH_DR  = 4'h2, TPM_EX1_DR = 4'h1, TPM_PA_DR  = 4'h3, TPM_EX2_DR = 4'h0,
    TPM_UPD_DR = 4'h5, TPM_SEL_IR = 4'h4, TPM_CAP_IR = 4'hE, TPM_SH_IR  = 4'hA,
    TPM_EX1_IR = 4'h9, TPM_PA_IR  = 4'hB, TPM_EX2_IR = 4'h8, TPM_UPD_IR = 4'hD
  } tpm_tap_t;
endpackage
`default_nettype wire

// ---- hdl/tpm_sync2.sv ----
`default_nettype none
module tpm_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  // two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    meta_reg <= d_i;
    q_o      <= meta_reg;
  end
endmodule
`default_nettype wire

// ---- hdl/tpm_tap_fsm.sv ----
`default_nettype none
module tpm_tap_fsm (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             tms_i,
  output var  tpm_pkg::tpm_tap_t state_o,
  output wire logic             shift_o
);
  tpm_pkg::tpm_tap_t state_next;

  // standard sixteen-state walk, stepped by mode select
  always_comb begin
    state_next = state_o;
    case (state_o)
      tpm_pkg::TPM_RESET:  state_next = tms_i ? tpm_pkg::TPM_RESET  : tpm_pkg::TPM_IDLE;
      tpm_pkg::TPM_IDLE:   state_next = tms_i ? tpm_pkg::TPM_SEL_DR : tpm_pkg::TPM_IDLE;
      tpm_pkg::TPM_SEL_DR: state_next = tms_i ? tpm_pkg::TPM_SEL_IR : tpm_pkg::TPM_CAP_DR;
      tpm_pkg::TPM_CAP_DR: state_next = tms_i ? tpm_pkg::TPM_EX1_DR : tpm_pkg::TPM_SH_DR;
      tpm_pkg::TPM_SH_DR:  state_next = tms_i ? tpm_pkg::TPM_EX1_DR : tpm_pkg::TPM_SH_DR;
      tpm_pkg::TPM_EX1_DR: state_next = tms_i ? tpm_pkg::TPM_UPD_DR : tpm_pkg::TPM_PA_DR;
      tpm_pkg::TPM_PA_DR:  state_next = tms_i ? tpm_pkg::TPM_EX2_DR : tpm_pkg::TPM_PA_DR;
      tpm_pkg::TPM_EX2_DR: state_next = tms_i ? tpm_pkg::TPM_UPD_DR : tpm_pkg::TPM_SH_DR;
      tpm_pkg::TPM_UPD_DR: state_next = tms_i ? tpm_pkg::TPM_SEL_DR : tpm_pkg::TPM_IDLE;
      tpm_pkg::TPM_SEL_IR: state_next = tms_i ? tpm_pkg::TPM_RESET  : tpm_pkg::TPM_CAP_IR;
      tpm_pkg::TPM_CAP_IR: state_next = tms_i ? tpm_pkg::TPM_EX1_IR : tpm_pkg::TPM_SH_IR;
      tpm_pkg::TPM_SH_IR:  state_next = tms_i ? tpm_pkg::TPM_EX1_IR : tpm_pkg::TPM_SH_IR;
      tpm_pkg::TPM_EX1_IR: state_next = tms_i ? tpm_pkg::TPM_UPD_IR : tpm_pkg::TPM_PA_IR;
      tpm_pkg::TPM_PA_IR:  state_next = tms_i ? tpm_pkg::TPM_EX2_IR : tpm_pkg::TPM_PA_IR;
      tpm_pkg::TPM_EX2_IR: state_next = tms_i ? tpm_pkg::TPM_UPD_IR : tpm_pkg::TPM_SH_IR;
      tpm_pkg::TPM_UPD_IR: state_next = tms_i ? tpm_pkg::TPM_SEL_DR : tpm_pkg::TPM_IDLE;
      default:             state_next = tpm_pkg::TPM_RESET;
    endcase
  end

  // state register on rising test clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_o <= tpm_pkg::TPM_RESET;
    end else begin
      state_o <= state_next;
    end
  end

  // shift states open the data output
  assign shift_o = (state_o == tpm_pkg::TPM_SH_DR) || (state_o == tpm_pkg::TPM_SH_IR);
endmodule
`default_nettype wire

// ---- hdl/tpm_pin_mux.sv ----
`default_nettype none
module tpm_pin_mux #(
  parameter logic [tpm_pkg::RST_CNT_W-1:0] RST_RELEASE_CYCLES = tpm_pkg::RST_RELEASE_DEF
) (
  input  wire logic                       CLOCK_I,
  input  wire logic                       SYS_RST_I,
  input  wire logic                       TCK_I,
  input  wire logic [tpm_pkg::PORTD_W-1:0] PORTD_PIN_I,
  output logic      [tpm_pkg::PORTD_W-1:0] PORTD_PIN_O,
  output logic      [tpm_pkg::PORTD_W-1:0] PORTD_PIN_OE_O,
  input  wire logic                       PORTA_BIT0_PIN_I,
  output var  logic                       PORTA_BIT0_PIN_O,
  output var  logic                       PORTA_BIT0_PIN_OE_O,
  input  wire logic [tpm_pkg::PORTD_W-1:0] PORT_PER_I,
  input  wire logic [tpm_pkg::PORTD_W-1:0] PERIPH_SELECT_REG_I,
  input  wire logic [tpm_pkg::PORTD_W-1:0] PORTD_DIR_I,
  input  wire logic [tpm_pkg::PORTD_W-1:0] PORTD_DOUT_I,
  output logic      [tpm_pkg::PORTD_W-1:0] PORTD_DIN_O,
  output var  logic [tpm_pkg::PORTD_W-1:0] PORTD_ALT_O,
  input  wire logic                       PORTA0_DIR_I,
  input  wire logic                       PORTA0_DOUT_I,
  output logic                            PORTA0_DIN_O,
  input  wire logic                       WATCHDOG_RESET_I,
  input  wire logic                       SW_RESET_I,
  output var  logic                       CHIP_RST_O,
  input  wire logic                       TAP_TDO_I,
  output var  logic                       TAP_TDI_O,
  output var  logic                       TAP_TMS_O,
  output tpm_pkg::tpm_tap_t               TAP_STATE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // system clock side: pin synchronisers

  logic [tpm_pkg::PORTD_W:0]     pin_sync;
  logic                          ext_reset_n_pin;

  // port D and port A pins into the system domain
  tpm_sync2 #(
    .W (tpm_pkg::PORTD_W + 1)
  ) u_pin_sync (
    .clk_i (CLOCK_I),
    .d_i   ({PORTA_BIT0_PIN_I, PORTD_PIN_I}),
    .q_o   (pin_sync)
  );

  // synchronised levels, reused for gpio reads and the reset cause
  assign PORTD_DIN_O     = pin_sync[tpm_pkg::PORTD_W-1:0];
  assign PORTA0_DIN_O    = pin_sync[tpm_pkg::PORTD_W];
  assign ext_reset_n_pin = pin_sync[tpm_pkg::PIN_RSTN];

  ////////////////////////////////////////////////////////////////////////////
  // reset generation

  logic                          rst_cause;
  logic                          pin_reset_role;
  logic [tpm_pkg::RST_CNT_W-1:0] rst_cnt_reg;
  logic [tpm_pkg::RST_CNT_W-1:0] rst_cnt_next;
  logic                          rst_done;
  logic                          mode_rst;

  // pin counts as a cause only in its reset role
  assign pin_reset_role = ~PORTD_ALT_O[tpm_pkg::PIN_RSTN];
  assign rst_cause      = SYS_RST_I | WATCHDOG_RESET_I | SW_RESET_I
                        | (pin_reset_role & ~ext_reset_n_pin);
  assign rst_done       = (rst_cnt_reg == RST_RELEASE_CYCLES);
  assign rst_cnt_next   = rst_done ? rst_cnt_reg : rst_cnt_reg + tpm_pkg::RST_CNT_ONE;
  assign mode_rst       = SYS_RST_I | CHIP_RST_O;

  // count from cause removal, release on the system clock
  always_ff @(posedge CLOCK_I) begin
    if (rst_cause) begin
      rst_cnt_reg <= tpm_pkg::RST_CNT_ZERO;
      CHIP_RST_O  <= 1'b1;
    end else begin
      rst_cnt_reg <= rst_cnt_next;
      CHIP_RST_O  <= ~rst_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin function select and gpio drive

  logic [tpm_pkg::PORTD_W-1:0] alt_next;
  logic [tpm_pkg::PORTD_W-1:0] gpio_out_reg;
  logic [tpm_pkg::PORTD_W-1:0] gpio_oe_reg;
  logic [tpm_pkg::PORTD_W-1:0] gpio_out_next;
  logic [tpm_pkg::PORTD_W-1:0] gpio_oe_next;

  // alternate role needs both enable and select
  assign alt_next = PORT_PER_I & PERIPH_SELECT_REG_I;

  // gpio drive; bit four only pulls low
  assign gpio_oe_next  = {PORTD_ALT_O[tpm_pkg::PIN_RSTN] & PORTD_DIR_I[tpm_pkg::PIN_RSTN]
                          & ~PORTD_DOUT_I[tpm_pkg::PIN_RSTN],
                          PORTD_ALT_O[tpm_pkg::PIN_RSTN-1:0] & PORTD_DIR_I[tpm_pkg::PIN_RSTN-1:0]};
  assign gpio_out_next = {1'b0, PORTD_DOUT_I[tpm_pkg::PIN_RSTN-1:0]};

  // mode and drive registers; reset returns pins to test roles
  always_ff @(posedge CLOCK_I) begin
    if (mode_rst) begin
      PORTD_ALT_O  <= tpm_pkg::PORTD_ZERO;
      gpio_out_reg <= tpm_pkg::PORTD_ZERO;
      gpio_oe_reg  <= tpm_pkg::PORTD_ZERO;
    end else begin
      PORTD_ALT_O  <= alt_next;
      gpio_out_reg <= gpio_out_next;
      gpio_oe_reg  <= gpio_oe_next;
    end
  end

  // port A bit zero is plain gpio, input after reset
  always_ff @(posedge CLOCK_I) begin
    if (mode_rst) begin
      PORTA_BIT0_PIN_O    <= 1'b0;
      PORTA_BIT0_PIN_OE_O <= 1'b0;
    end else begin
      PORTA_BIT0_PIN_O    <= PORTA0_DOUT_I;
      PORTA_BIT0_PIN_OE_O <= PORTA0_DIR_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // test clock side

  logic [2:0] roles_tck;
  logic       rst_tck;
  logic       tdi_role;
  logic       tms_role;
  logic       tms_eff;
  logic       tdi_eff;
  logic       tap_shift;
  logic       tdo_reg;
  logic       tdo_oe_reg;

  // reset and role levels crossed into the test clock domain
  tpm_sync2 #(
    .W (3)
  ) u_tck_sync (
    .clk_i (TCK_I),
    .d_i   ({mode_rst, ~PORTD_ALT_O[tpm_pkg::PIN_TMS], ~PORTD_ALT_O[tpm_pkg::PIN_TDI]}),
    .q_o   (roles_tck)
  );

  assign rst_tck  = roles_tck[2];
  assign tms_role = roles_tck[1];
  assign tdi_role = roles_tck[0];
  // a pin lent to gpio looks like an idle pulled-up line
  assign tms_eff  = tms_role ? PORTD_PIN_I[tpm_pkg::PIN_TMS] : 1'b1;
  assign tdi_eff  = tdi_role ? PORTD_PIN_I[tpm_pkg::PIN_TDI] : 1'b1;

  // capture data and mode select on rising test clock
  always_ff @(posedge TCK_I) begin
    TAP_TDI_O <= tdi_eff;
    TAP_TMS_O <= tms_eff;
  end

  // controller stepped only by the test clock
  tpm_tap_fsm u_tap (
    .clk_i   (TCK_I),
    .rst_i   (rst_tck),
    .tms_i   (tms_eff),
    .state_o (TAP_STATE_O),
    .shift_o (tap_shift)
  );

  // output data and enable move on falling test clock
  always_ff @(negedge TCK_I) begin
    if (rst_tck) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_reg    <= TAP_TDO_I;
      tdo_oe_reg <= tap_shift;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad outputs

  // data output pin follows the test path unless lent to gpio
  assign PORTD_PIN_O    = {gpio_out_reg[tpm_pkg::PORTD_W-1:tpm_pkg::PIN_TDO+1],
                           PORTD_ALT_O[tpm_pkg::PIN_TDO] ? gpio_out_reg[tpm_pkg::PIN_TDO] : tdo_reg,
                           gpio_out_reg[tpm_pkg::PIN_TDI]};
  assign PORTD_PIN_OE_O = {gpio_oe_reg[tpm_pkg::PORTD_W-1:tpm_pkg::PIN_TDO+1],
                           PORTD_ALT_O[tpm_pkg::PIN_TDO] ? gpio_oe_reg[tpm_pkg::PIN_TDO] : tdo_oe_reg,
                           gpio_oe_reg[tpm_pkg::PIN_TDI]};

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_reset_hold: assert property (
    @(posedge CLOCK_I) (pin_reset_role && !ext_reset_n_pin) |=> CHIP_RST_O ##1 CHIP_RST_O)
    else $error("reset pin low did not hold reset");

  a_release_count: assert property (
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    $fell(CHIP_RST_O) |-> ($past(rst_cnt_reg) == RST_RELEASE_CYCLES))
    else $error("reset released at wrong count");

  a_test_default: assert property (
    @(posedge CLOCK_I) CHIP_RST_O |=> (PORTD_ALT_O == tpm_pkg::PORTD_ZERO))
    else $error("port D not back in test role after reset");

  a_pin_ignored: assert property (
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (PORTD_ALT_O[tpm_pkg::PIN_RSTN] && !CHIP_RST_O && !WATCHDOG_RESET_I && !SW_RESET_I)
    |=> !CHIP_RST_O)
    else $error("gpio reset pin caused a reset");

  a_open_drain: assert property (
    @(posedge CLOCK_I) PORTD_PIN_OE_O[tpm_pkg::PIN_RSTN] |-> !PORTD_PIN_O[tpm_pkg::PIN_RSTN])
    else $error("reset pin driven high");

  a_porta_input: assert property (
    @(posedge CLOCK_I) SYS_RST_I |=> !PORTA_BIT0_PIN_OE_O)
    else $error("port A bit zero not input after reset");

  a_alt_select: assert property (
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    !$past(mode_rst) |-> (PORTD_ALT_O == ($past(PORT_PER_I) & $past(PERIPH_SELECT_REG_I))))
    else $error("alternate role without enable and select");

  a_tdo_shift: assert property (
    @(negedge TCK_I) disable iff (rst_tck) 1'b1 |=> (tdo_oe_reg == $past(tap_shift)))
    else $error("data output enable outside shift states");

  a_tdi_capture: assert property (
    @(posedge TCK_I) disable iff (rst_tck)
    tdi_role |=> (TAP_TDI_O == $past(PORTD_PIN_I[tpm_pkg::PIN_TDI])))
    else $error("test data not captured on rising edge");

  a_tms_idle: assert property (
    @(posedge TCK_I) disable iff (rst_tck) !tms_role [*2] |=> TAP_TMS_O)
    else $error("idle mode select not read as one");

  // reset sources, pin paths and test clock capture
  a_pin_sync_depth: assert property (
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    1'b1 |-> (ext_reset_n_pin == $past(PORTD_PIN_I[tpm_pkg::PIN_RSTN], 2)))
    else $error("reset pin not seen through two stages");

  a_cause_resets: assert property (
    @(posedge CLOCK_I)
    (WATCHDOG_RESET_I || SW_RESET_I) |=> (CHIP_RST_O && (rst_cnt_reg == tpm_pkg::RST_CNT_ZERO)))
    else $error("watchdog or software reset not taken");

  a_release_wait: assert property (
    @(posedge CLOCK_I)
    (!rst_cause && !rst_done) |=> CHIP_RST_O)
    else $error("reset released before count reached");

  a_porta_follow: assert property (
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    !$past(mode_rst) |-> (PORTA_BIT0_PIN_OE_O == $past(PORTA0_DIR_I)))
    else $error("port A bit zero enable not from direction");

  a_drain_only: assert property (
    @(posedge CLOCK_I) PORTD_PIN_OE_O[tpm_pkg::PIN_RSTN] |-> ($past(PORTD_ALT_O[tpm_pkg::PIN_RSTN])
    && $past(PORTD_DIR_I[tpm_pkg::PIN_RSTN]) && !$past(PORTD_DOUT_I[tpm_pkg::PIN_RSTN])))
    else $error("reset pin driven outside open-drain low");

  a_alt_needs_per: assert property (
    @(posedge CLOCK_I)
    (|PORTD_ALT_O) |-> (|($past(PORT_PER_I) & $past(PERIPH_SELECT_REG_I))))
    else $error("alternate role set with no request");

  a_tms_capture: assert property (
    @(posedge TCK_I) disable iff (rst_tck)
    tms_role |=> (TAP_TMS_O == $past(PORTD_PIN_I[tpm_pkg::PIN_TMS])))
    else $error("mode select not captured on rising edge");

  a_tdi_idle: assert property (
    @(posedge TCK_I) disable iff (rst_tck)
    !tdi_role [*2] |=> TAP_TDI_O)
    else $error("idle test data not read as one");

  a_state_reset: assert property (
    @(posedge TCK_I)
    rst_tck |=> (TAP_STATE_O == tpm_pkg::TPM_RESET))
    else $error("controller not reset by test clock");

  a_tdo_follow: assert property (
    @(negedge TCK_I) disable iff (rst_tck)
    1'b1 |=> (tdo_reg == $past(TAP_TDO_I)))
    else $error("data output not updated on falling edge");

endmodule
`default_nettype wire

// ---- test/tpm_probe.sv ----
`default_nettype none
// debug probe and board reset source seen from the pads
module tpm_probe (
  input  wire logic tdo_pad_i,
  output var  logic tck_o,
  output var  logic tms_o,
  output var  logic tdi_o,
  output var  logic drv_o,
  output var  logic rst_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tdo_seen;
  // idle: test clock stopped low, board reset released
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    drv_o = 1'b1;
    rst_n_o = 1'b1;
    tdo_seen = 1'b0;
  end
  // one 30 ns test clock period; levels set while the clock is low
  task automatic shift(input logic tms, input logic tdi);
    tms_o = tms;
    tdi_o = tdi;
    #15 tck_o = 1'b1;
    tdo_seen = tdo_pad_i;
    // past the rising edge the lines show the inverse, exposing late sampling
    #7 tms_o = ~tms;
    tdi_o = ~tdi;
    #8 tck_o = 1'b0;
  endtask
  // board reset line, changed on a system clock edge
  task automatic set_rst(input logic v);
    rst_n_o <= v;
  endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] R = 16'h0004;
  logic clk, sys_rst, pa_dir, pa_dout, wdog, swr, tdo_src, tdi, tms, drv, rst_n, tck, pa_o, pa_oe, pa_din, chip_rst;
  logic [4:0] pad, pin_o, oe, per, sel, dir, dout, din, alt;
  logic tap_tdi, tap_tms;
  tpm_pkg::tpm_tap_t state;
  int num_errors, samples_checked;
  ////////////////////////////////////////////////////////////
  // pad resolution: pull-ups where nobody drives
  assign pad[0] = oe[0] ? pin_o[0] : (drv ? tdi : 1'b1);
  assign pad[1] = oe[1] ? pin_o[1] : 1'b1;
  assign pad[2] = oe[2] ? pin_o[2] : (drv ? tck : 1'b1);
  assign pad[3] = oe[3] ? pin_o[3] : (drv ? tms : 1'b1);
  assign pad[4] = oe[4] ? pin_o[4] : rst_n;
  tpm_probe probe_inst (.tdo_pad_i(pad[1]), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .drv_o(drv), .rst_n_o(rst_n));
  tpm_pin_mux #(.RST_RELEASE_CYCLES(R)) tpm_pin_mux_inst (
    .CLOCK_I(clk), .SYS_RST_I(sys_rst), .TCK_I(pad[2]), .PORTD_PIN_I(pad), .PORTD_PIN_O(pin_o),
    .PORTD_PIN_OE_O(oe), .PORTA_BIT0_PIN_I(pa_oe ? pa_o : 1'b1), .PORTA_BIT0_PIN_O(pa_o),
    .PORTA_BIT0_PIN_OE_O(pa_oe), .PORT_PER_I(per), .PERIPH_SELECT_REG_I(sel), .PORTD_DIR_I(dir),
    .PORTD_DOUT_I(dout), .PORTD_DIN_O(din), .PORTD_ALT_O(alt), .PORTA0_DIR_I(pa_dir),
    .PORTA0_DOUT_I(pa_dout), .PORTA0_DIN_O(pa_din), .WATCHDOG_RESET_I(wdog), .SW_RESET_I(swr),
    .CHIP_RST_O(chip_rst), .TAP_TDO_I(tdo_src), .TAP_TDI_O(tap_tdi), .TAP_TMS_O(tap_tms), .TAP_STATE_O(state));
  ////////////////////////////////////////////////////////////
  // system clock 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // shared helpers
  task automatic chk(input string nm, input logic [4:0] exp, input logic [4:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input logic m, input logic d, input tpm_pkg::tpm_tap_t s);
    probe_inst.shift(m, d);
    #2 chk("tap state", {1'b0, s}, {1'b0, state});
  endtask
  // edges from the driving edge until the internal reset drops
  task automatic rel(input logic [4:0] exp);
    logic [4:0] n;
    n = 5'h00;
    do begin
      @(posedge clk);
      n++;
      @(negedge clk);
    end while (chip_rst !== 1'b0 && n < 5'h1F);
    chk("release edges", exp, n);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // power-on reset, defaults and controller reset
  task automatic t_reset();
    @(negedge clk);
    repeat (4) probe_inst.shift(1'b1, 1'b1);
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk("reset level", 5'h01, {4'h0, chip_rst});
    chk("roles", 5'h00, alt);
    chk("pad enables", 5'h00, oe);
    chk("porta enable", 5'h00, {4'h0, pa_oe});
    @(posedge clk);
    sys_rst <= 1'b0;
    rel(5'(R + 16'h0001));
    repeat (5) probe_inst.shift(1'b1, 1'b1);
    #2 chk("tap state", {1'b0, tpm_pkg::TPM_RESET}, {1'b0, state});
  endtask
  // data and instruction shifts with the output pad
  task automatic t_walk();
    step(1'b0, 1'b1, tpm_pkg::TPM_IDLE);
    step(1'b1, 1'b0, tpm_pkg::TPM_SEL_DR);
    @(posedge clk) tdo_src <= 1'b1;
    step(1'b0, 1'b1, tpm_pkg::TPM_CAP_DR);
    chk("captured data", 5'h01, {4'h0, tap_tdi});
    step(1'b0, 1'b0, tpm_pkg::TPM_SH_DR);
    chk("captured data", 5'h00, {4'h0, tap_tdi});
    chk("out enable", 5'h01, {4'h0, oe[1]});
    chk("out pad", 5'h01, {4'h0, pad[1]});
    @(posedge clk) tdo_src <= 1'b0;
    step(1'b0, 1'b1, tpm_pkg::TPM_SH_DR);
    chk("out at rise", 5'h01, {4'h0, probe_inst.tdo_seen});
    chk("out pad", 5'h00, {4'h0, pad[1]});
    step(1'b1, 1'b1, tpm_pkg::TPM_EX1_DR);
    chk("out enable", 5'h00, {4'h0, oe[1]});
    step(1'b1, 1'b0, tpm_pkg::TPM_UPD_DR);
    step(1'b1, 1'b0, tpm_pkg::TPM_SEL_DR);
    step(1'b1, 1'b0, tpm_pkg::TPM_SEL_IR);
    step(1'b0, 1'b0, tpm_pkg::TPM_CAP_IR);
    step(1'b0, 1'b0, tpm_pkg::TPM_SH_IR);
    chk("out enable", 5'h01, {4'h0, oe[1]});
    step(1'b1, 1'b0, tpm_pkg::TPM_EX1_IR);
    chk("out enable", 5'h00, {4'h0, oe[1]});
  endtask
  // board reset pin in its reset role
  task automatic t_pin();
    @(posedge clk) probe_inst.set_rst(1'b0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("pin reset", 5'h01, {4'h0, chip_rst});
    repeat (4) @(posedge clk);
    probe_inst.set_rst(1'b1);
    rel(5'(R + 16'h0003));
  endtask
  // reset pin as open-drain port bit, then other reset causes
  task automatic t_gpio();
    @(posedge clk) per <= 5'h10;
    repeat (3) @(posedge clk);
    @(negedge clk) chk("roles", 5'h00, alt);
    @(posedge clk) sel <= 5'h19;
    per <= 5'h19;
    repeat (3) @(posedge clk);
    @(negedge clk) chk("roles", 5'h19, alt);
    repeat (5) probe_inst.shift(1'b0, 1'b0);
    #2 chk("gpio data to tap", 5'h01, {4'h0, tap_tdi});
    chk("gpio mode to tap", 5'h01, {4'h0, tap_tms});
    @(posedge clk) probe_inst.set_rst(1'b0);
    dir <= 5'h10;
    repeat (6) @(posedge clk);
    @(negedge clk) chk("pin ignored", 5'h00, {4'h0, chip_rst});
    chk("open drain", 5'h10, {oe[4], 3'h0, pin_o[4]});
    @(posedge clk) dout <= 5'h10;
    probe_inst.set_rst(1'b1);
    repeat (3) @(posedge clk);
    @(negedge clk) chk("open drain off", 5'h10, {din[4], 3'h0, oe[4]});
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) wdog <= (i == 0);
      swr <= (i == 1);
      @(posedge clk) wdog <= 1'b0;
      swr <= 1'b0;
      rel(5'(R + 16'h0001));
      chk("roles after reset", 5'h00, alt);
    end
    @(posedge clk) pa_dir <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk) chk("porta out", 5'h01, {pa_din, pa_o, 2'h0, pa_oe});
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    num_errors = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    {pa_dir, pa_dout, wdog, swr, tdo_src} = 5'h00;
    {per, sel, dir, dout} = 20'h00000;
    t_reset();
    t_walk();
    t_pin();
    t_gpio();
    give_verdict();
  end
  // hang guard, far beyond the few microseconds the tests need
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
